// ### bench/dacalu_core_properties.sv
`timescale 1ns/1ps
module dacalu_core_properties (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic rstn_i,
   // Watched ports
   input wire dacalu_pkg::dacalu_req_t req_i,
   input wire dacalu_pkg::dacalu_rsp_t rsp_o
);
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rstn_i);
   logic take;
   logic hit;
   assign take = req_i.valid && req_i.op <= dacalu_pkg::DACALU_OP_ADC;
   assign hit = req_i.accum[3:0] > 4'h9 || req_i.flags.half_carry_flag;
   a_answer_follows: assert property (take |=> rsp_o.valid)
      else $error("answer missing");
   a_no_spurious: assert property (!req_i.valid |=> !rsp_o.valid)
      else $error("answer without request");
   a_dit_kept: assert property (take |=> rsp_o.flags[7:5] ==
      $past(req_i.flags[7:5])) else $error("D/I/T changed");
   a_add_hit: assert property (take && hit && req_i.op ==
      dacalu_pkg::DACALU_OP_ADD_ADJ |=> rsp_o.result[15:8] ==
      $past(req_i.accum[15:8]) + 8'h01) else $error("add adjust high");
   a_sub_hit: assert property (take && hit && req_i.op ==
      dacalu_pkg::DACALU_OP_SUB_ADJ |=> rsp_o.result[15:8] ==
      $past(req_i.accum[15:8]) - 8'h01) else $error("sub adjust high");
   a_adj_cf_af: assert property (take && req_i.op <=
      dacalu_pkg::DACALU_OP_SUB_ADJ |=> rsp_o.result[7:4] == 4'h0 &&
      rsp_o.flags.carry_flag == rsp_o.flags.half_carry_flag)
      else $error("adjust carry or mask");
   a_div_high: assert property (take && req_i.op ==
      dacalu_pkg::DACALU_OP_DIV_ADJ |=> rsp_o.result[15:8] == 8'h00 &&
      rsp_o.flags.zero_flag == (rsp_o.result[7:0] == 8'h00))
      else $error("div adjust high or zero");
   a_mul_parity: assert property (take && req_i.op ==
      dacalu_pkg::DACALU_OP_MUL_ADJ |=> rsp_o.result[7:0] < 8'h0a &&
      rsp_o.flags.parity_flag == ~^rsp_o.result[7:0])
      else $error("mul adjust digit or parity");
   a_adc_byte: assert property (take && !req_i.word && req_i.op ==
      dacalu_pkg::DACALU_OP_ADC |=> rsp_o.result[15:8] == 8'h00 &&
      rsp_o.flags.sign_flag == rsp_o.result[7])
      else $error("byte add sign or upper");
endmodule
bind dacalu_core dacalu_core_properties chk_u (
   .sys_clk_i(sys_clk_i),
   .rstn_i(rstn_i),
   .req_i(req_i),
   .rsp_o(rsp_o)
);

// ### bench/decimal_adjust_and_carry_add_alu_tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_errors++; \
   $display("mismatch at %0t: got %h want %h", $time, a, b); end end
module decimal_adjust_and_carry_add_alu_tb_top;
   logic sys_clk_i = 1'b0;
   logic rstn_i = 1'b0;
   dacalu_pkg::dacalu_req_t req = '0;
   dacalu_pkg::dacalu_rsp_t rsp;
   int n_errors = 0;
   int cmp_count = 0;
   int cyc = 0;
   logic [15:0] sums [6] = '{16'h30, 16'h30, 16'h30, 16'h13, 16'h23, 16'h103};
   dacalu_core dut_u (
      .sys_clk_i(sys_clk_i),
      .rstn_i(rstn_i),
      .req_i(req),
      .rsp_o(rsp)
   );
   always #50 sys_clk_i = ~sys_clk_i;
   task automatic conclude();
      if (n_errors == 0 && cmp_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // Hang guard, far above the 25 or so cycles used
   always @(posedge sys_clk_i) begin
      cyc++;
      if (cyc == 2000) begin
         n_errors++;
         conclude();
      end
   end
   // Valid held high between calls, so calls run back to back
   task automatic go(input dacalu_pkg::dacalu_op_t op,
      input logic [2:0] fm, input logic w,
      input logic [15:0] a, input logic [15:0] r, input logic [15:0] m,
      input logic [15:0] i, input logic [8:0] f);
      req = '{1'b1, op, dacalu_pkg::dacalu_form_t'(fm), w, a, r, m, i, f};
      @(posedge sys_clk_i);
      #5;
      `CHK(rsp.valid, 1'b1)
      `CHK(rsp.flags[7:5], f[7:5])
   endtask
   task automatic t_adjust_add_sub();
      go(dacalu_pkg::DACALU_OP_ADD_ADJ, '0, 1'b0, 16'h020b, 0, 0, 0, 9'h0e0);
      `CHK({rsp.result, rsp.flags[2], rsp.flags[0]}, {16'h0301, 2'b11})
      go(dacalu_pkg::DACALU_OP_ADD_ADJ, '0, 1'b0, 16'h0102, 0, 0, 0, 9'h0e4);
      `CHK({rsp.result, rsp.flags[2], rsp.flags[0]}, {16'h0208, 2'b11})
      go(dacalu_pkg::DACALU_OP_ADD_ADJ, '0, 1'b0, 16'h0235, 0, 0, 0, 9'h0e0);
      `CHK({rsp.result, rsp.flags[2], rsp.flags[0]}, {16'h0205, 2'b00})
      go(dacalu_pkg::DACALU_OP_SUB_ADJ, '0, 1'b0, 16'h000e, 0, 0, 0, 9'h0e0);
      `CHK({rsp.result, rsp.flags[2], rsp.flags[0]}, {16'hff08, 2'b11})
      go(dacalu_pkg::DACALU_OP_SUB_ADJ, '0, 1'b0, 16'h0203, 0, 0, 0, 9'h0e4);
      `CHK({rsp.result, rsp.flags[2], rsp.flags[0]}, {16'h010d, 2'b11})
      go(dacalu_pkg::DACALU_OP_SUB_ADJ, '0, 1'b0, 16'h0337, 0, 0, 0, 9'h0e0);
      `CHK({rsp.result, rsp.flags[2], rsp.flags[0]}, {16'h0307, 2'b00})
   endtask
   task automatic t_adjust_mul_div();
      go(dacalu_pkg::DACALU_OP_DIV_ADJ, '0, 1'b0, 16'h0705, 0, 0, 0, 9'h0e0);
      `CHK({rsp.result, rsp.flags[1], rsp.flags[4:3]}, {16'h004b, 3'b100})
      go(dacalu_pkg::DACALU_OP_DIV_ADJ, '0, 1'b0, 16'h0d00, 0, 0, 0, 9'h0e0);
      `CHK({rsp.result, rsp.flags[1], rsp.flags[4:3]}, {16'h0082, 3'b110})
      go(dacalu_pkg::DACALU_OP_MUL_ADJ, '0, 1'b0, 16'h0051, 0, 0, 0, 9'h0e0);
      `CHK({rsp.result, rsp.flags[1], rsp.flags[4:3]}, {16'h0801, 3'b000})
      go(dacalu_pkg::DACALU_OP_MUL_ADJ, '0, 1'b0, 16'h3300, 0, 0, 0, 9'h0e0);
      `CHK({rsp.result, rsp.flags[1], rsp.flags[4:3]}, {16'h0000, 3'b101})
   endtask
   task automatic t_add_carry();
      go(dacalu_pkg::DACALU_OP_ADC, dacalu_pkg::DACALU_SRC_REG_IMM, 1'b0, 0,
         16'h007f, 0, 16'h0000, 9'h0e1);
      `CHK({rsp.result, rsp.flags[8], rsp.flags[4:0]}, {16'h80, 6'b110100})
      go(dacalu_pkg::DACALU_OP_ADC, dacalu_pkg::DACALU_SRC_REG_IMM, 1'b1, 0,
         16'hffff, 0, 16'h0001, 9'h0e0);
      `CHK({rsp.result, rsp.flags[8], rsp.flags[4:0]}, {16'h0, 6'b001111})
      for (int k = 0; k < 6; k++) begin
         go(dacalu_pkg::DACALU_OP_ADC, dacalu_pkg::dacalu_form_t'(k), 1'b1,
            16'h0100, 16'h0010, 16'h0020, 16'h0003, 9'h0e0);
         `CHK(rsp.result, sums[k])
         `CHK({rsp.to_mem, rsp.to_accum}, {k == 2 || k == 4, k == 5})
      end
      req.valid = 1'b0;
      @(posedge sys_clk_i);
      #5;
      `CHK(rsp.valid, 1'b0)
   endtask
   initial begin
      repeat (6) @(posedge sys_clk_i);
      `CHK(rsp, '0)
      #5;
      rstn_i = 1'b1;
      t_adjust_add_sub();
      t_adjust_mul_div();
      t_add_carry();
      conclude();
   end
endmodule

// ### rtl/dacalu_core.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Add adjust adds 6 to low byte, bumps high byte on digit >9 or A.
// - Add adjust updates A and C, leaves O/P/S/Z undefined, D/I/T kept.
// - Sub adjust subtracts 6, decrements high byte on digit >9 or AF.
// - Sub adjust updates A and C, O/P/S/Z undefined, D/I/T kept.
// - Div adjust forms high times ten plus low in low byte, clears high.
// - Div adjust sets P/S/Z from result, A/C/O undefined, D/I/T kept.
// - Mul adjust puts low div ten in high byte and remainder in low.
// - Mul adjust sets P/S/Z from result, A/C/O undefined, D/I/T kept.
// - Add with carry sums destination, source and the carry flag.
// - Add with carry takes all six register, memory, immediate forms.
// - Half carry marks carry or borrow across the low nibble.
// - Parity is set when the low result byte has even ones.
// - Carry marks carry or borrow at the result top bit.
// - Overflow marks a signed result that does not fit the width.
module dacalu_core (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic rstn_i,
   // Request
   input wire dacalu_pkg::dacalu_req_t req_i,
   // Answer
   output dacalu_pkg::dacalu_rsp_t rsp_o
);

   dacalu_pkg::dacalu_rsp_t rsp_ff;
   dacalu_pkg::dacalu_rsp_t nxt_rsp;

   logic [15:0] dst;
   logic [15:0] src;
   logic [16:0] sum;
   logic [4:0] nib_sum;
   logic [15:0] pss_val;
   logic par_w;
   logic sgn_w;
   logic zer_w;

   logic [7:0] lo_byte;
   logic [7:0] hi_byte;
   logic adj_hit;
   logic [15:0] mul_prod;
   logic [7:0] div_res;

   always_comb begin
      dst = req_i.reg_val;
      src = req_i.reg_val;
      case (req_i.form)
         dacalu_pkg::DACALU_SRC_REG_REG: begin
            dst = req_i.reg_val;
            src = req_i.mem_val;
         end
         dacalu_pkg::DACALU_SRC_REG_MEM: begin
            dst = req_i.reg_val;
            src = req_i.mem_val;
         end
         dacalu_pkg::DACALU_SRC_MEM_REG: begin
            dst = req_i.mem_val;
            src = req_i.reg_val;
         end
         dacalu_pkg::DACALU_SRC_REG_IMM: begin
            dst = req_i.reg_val;
            src = req_i.imm_val;
         end
         dacalu_pkg::DACALU_SRC_MEM_IMM: begin
            dst = req_i.mem_val;
            src = req_i.imm_val;
         end
         dacalu_pkg::DACALU_SRC_ACC_IMM: begin
            dst = req_i.accum;
            src = req_i.imm_val;
         end
         default: begin
            dst = req_i.reg_val;
            src = req_i.mem_val;
         end
      endcase
      if (!req_i.word) begin
         dst = {8'h00, dst[7:0]};
         src = {8'h00, src[7:0]};
      end
   end

   always_comb begin
      sum = {1'b0, dst} + {1'b0, src}
            + {16'h0000, req_i.flags.carry_flag};
      nib_sum = {1'b0, dst[3:0]} + {1'b0, src[3:0]}
                + {4'h0, req_i.flags.carry_flag};
   end

   // Decimal adjust operands
   always_comb begin
      lo_byte = req_i.accum[7:0];
      hi_byte = req_i.accum[15:8];
      adj_hit = (lo_byte[3:0] > dacalu_pkg::DACALU_NIB_MAX)
                || req_i.flags.half_carry_flag;
      // Ten is a constant, so the product folds to shifts and adds
      mul_prod = hi_byte * dacalu_pkg::DACALU_RADIX;
      div_res = mul_prod[7:0] + lo_byte;
   end

   // Kept apart from the answer logic so no loop runs through the flags
   always_comb begin
      case (req_i.op)
         dacalu_pkg::DACALU_OP_DIV_ADJ: begin
            pss_val = {8'h00, div_res};
         end
         dacalu_pkg::DACALU_OP_MUL_ADJ: begin
            pss_val = {8'h00, lo_byte % dacalu_pkg::DACALU_RADIX};
         end
         default: begin
            pss_val = sum[15:0];
         end
      endcase
   end

   dacalu_flag_calc u_flag_calc (
      .value_i(pss_val),
      .word_i(req_i.op == dacalu_pkg::DACALU_OP_ADC ? req_i.word : 1'b0),
      .parity_o(par_w),
      .sign_o(sgn_w),
      .zero_o(zer_w)
   );

   always_comb begin
      nxt_rsp = rsp_ff;
      nxt_rsp.valid = 1'b0;
      if (req_i.valid) begin
         nxt_rsp.valid = 1'b1;
         nxt_rsp.to_mem = 1'b0;
         nxt_rsp.to_accum = 1'b1;
         // Undefined flags are passed through unchanged
         nxt_rsp.flags = req_i.flags;
         case (req_i.op)
            dacalu_pkg::DACALU_OP_ADD_ADJ: begin
               if (adj_hit) begin
                  nxt_rsp.result[7:0] = (lo_byte + dacalu_pkg::DACALU_ADJ_SIX)
                                        & dacalu_pkg::DACALU_LOW_MASK;
                  nxt_rsp.result[15:8] = hi_byte + 8'h01;
               end else begin
                  nxt_rsp.result[7:0] = lo_byte
                                        & dacalu_pkg::DACALU_LOW_MASK;
                  nxt_rsp.result[15:8] = hi_byte;
               end
               nxt_rsp.flags.half_carry_flag = adj_hit;
               nxt_rsp.flags.carry_flag = adj_hit;
            end
            dacalu_pkg::DACALU_OP_SUB_ADJ: begin
               if (adj_hit) begin
                  nxt_rsp.result[7:0] = (lo_byte - dacalu_pkg::DACALU_ADJ_SIX)
                                        & dacalu_pkg::DACALU_LOW_MASK;
                  nxt_rsp.result[15:8] = hi_byte - 8'h01;
               end else begin
                  nxt_rsp.result[7:0] = lo_byte
                                        & dacalu_pkg::DACALU_LOW_MASK;
                  nxt_rsp.result[15:8] = hi_byte;
               end
               nxt_rsp.flags.half_carry_flag = adj_hit;
               nxt_rsp.flags.carry_flag = adj_hit;
            end
            dacalu_pkg::DACALU_OP_DIV_ADJ: begin
               nxt_rsp.result = {8'h00, div_res};
               nxt_rsp.flags.parity_flag = par_w;
               nxt_rsp.flags.sign_flag = sgn_w;
               nxt_rsp.flags.zero_flag = zer_w;
            end
            dacalu_pkg::DACALU_OP_MUL_ADJ: begin
               nxt_rsp.result[15:8] = lo_byte / dacalu_pkg::DACALU_RADIX;
               nxt_rsp.result[7:0] = lo_byte % dacalu_pkg::DACALU_RADIX;
               nxt_rsp.flags.parity_flag = par_w;
               nxt_rsp.flags.sign_flag = sgn_w;
               nxt_rsp.flags.zero_flag = zer_w;
            end
            dacalu_pkg::DACALU_OP_ADC: begin
               nxt_rsp.result = req_i.word ? sum[15:0]
                                           : {8'h00, sum[7:0]};
               nxt_rsp.to_mem = (req_i.form == dacalu_pkg::DACALU_SRC_MEM_REG)
                  || (req_i.form == dacalu_pkg::DACALU_SRC_MEM_IMM);
               nxt_rsp.to_accum =
                  (req_i.form == dacalu_pkg::DACALU_SRC_ACC_IMM);
               nxt_rsp.flags.parity_flag = par_w;
               nxt_rsp.flags.zero_flag = zer_w;
               nxt_rsp.flags.half_carry_flag = nib_sum[4];
               nxt_rsp.flags.carry_flag = req_i.word ? sum[16] : sum[8];
               if (req_i.word) begin
                  nxt_rsp.flags.overflow_flag = (dst[15] == src[15])
                                                && (sum[15] != dst[15]);
               end else begin
                  nxt_rsp.flags.overflow_flag = (dst[7] == src[7])
                                                && (sum[7] != dst[7]);
               end
               nxt_rsp.flags.sign_flag = sgn_w;
            end
            default: begin
               nxt_rsp.valid = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rsp_ff.valid <= 1'b0;
         rsp_ff.to_mem <= 1'b0;
         rsp_ff.to_accum <= 1'b0;
         rsp_ff.result <= dacalu_pkg::DACALU_RST_RESULT;
         rsp_ff.flags <= dacalu_pkg::DACALU_RST_FLAGS;
      end else begin
         rsp_ff <= nxt_rsp;
      end
   end

   assign rsp_o = rsp_ff;

endmodule

// ### rtl/dacalu_flag_calc.sv
`timescale 1ns/1ps
// Parity, sign and zero of a byte or word result
module dacalu_flag_calc (
   // Result
   input wire logic [15:0] value_i,
   input wire logic word_i,
   // Flags
   output logic parity_o,
   output logic sign_o,
   output logic zero_o
);
   always_comb begin
      parity_o = ~(^value_i[7:0]);
      sign_o = word_i ? value_i[15] : value_i[7];
      zero_o = word_i ? (value_i == 16'h0000) : (value_i[7:0] == 8'h00);
   end
endmodule

// ### rtl/dacalu_pkg.sv
package dacalu_pkg;

   typedef enum logic [2:0] {
      DACALU_OP_ADD_ADJ,
      DACALU_OP_SUB_ADJ,
      DACALU_OP_MUL_ADJ,
      DACALU_OP_DIV_ADJ,
      DACALU_OP_ADC
   } dacalu_op_t;

   typedef enum logic [2:0] {
      DACALU_SRC_REG_REG,
      DACALU_SRC_REG_MEM,
      DACALU_SRC_MEM_REG,
      DACALU_SRC_REG_IMM,
      DACALU_SRC_MEM_IMM,
      DACALU_SRC_ACC_IMM
   } dacalu_form_t;

   // Flag word as held by the core
   typedef struct packed {
      logic overflow_flag;
      logic direction_flag;
      logic interrupt_enable_flag;
      logic single_step_flag;
      logic sign_flag;
      logic zero_flag;
      logic half_carry_flag;
      logic parity_flag;
      logic carry_flag;
   } dacalu_flags_t;

   typedef struct packed {
      logic valid;
      dacalu_op_t op;
      dacalu_form_t form;
      logic word;
      logic [15:0] accum;
      logic [15:0] reg_val;
      logic [15:0] mem_val;
      logic [15:0] imm_val;
      dacalu_flags_t flags;
   } dacalu_req_t;

   typedef struct packed {
      logic valid;
      logic to_mem;
      logic to_accum;
      logic [15:0] result;
      dacalu_flags_t flags;
   } dacalu_rsp_t;

   localparam logic [3:0] DACALU_NIB_MAX = 4'h9;
   localparam logic [7:0] DACALU_ADJ_SIX = 8'h06;
   localparam logic [7:0] DACALU_LOW_MASK = 8'h0f;
   localparam logic [7:0] DACALU_RADIX = 8'h0a;
   localparam logic [15:0] DACALU_RST_RESULT = 16'h0000;
   localparam logic [8:0] DACALU_RST_FLAGS = 9'h000;
   localparam int DACALU_LATENCY = 1;

endpackage
